//--- verilog/ict_pkg.sv
// Constants for the instruction cycle timing sequencer
package ict_pkg;

  // ==================================================
  // Instruction word fields
  localparam int unsigned OP_W = 16;
  localparam logic [4:0] EXT_PREFIX = 5'h03; // Bits 15:11 of 1800h..1FFFh
  localparam logic [2:0] JUMP_TOP = 3'h1; // Bits 15:13 = 001
  localparam logic [5:0] FMT2_TOP = 6'h04; // Bits 15:10 = 000100

  // Single-operand op field, bits 9:7
  localparam logic [2:0] F2_RRC = 3'h0;
  localparam logic [2:0] F2_BYTE_SWAP = 3'h1;
  localparam logic [2:0] F2_RRA = 3'h2;
  localparam logic [2:0] F2_SXT = 3'h3;
  localparam logic [2:0] F2_PUSH = 3'h4;
  localparam logic [2:0] F2_CALL = 3'h5;
  localparam logic [2:0] F2_RETURN_FROM_INTERRUPT = 3'h6;

  // Double-operand op field, bits 15:12
  localparam logic [3:0] F1_MOV = 4'h4;
  localparam logic [3:0] F1_CMP = 4'h9;
  localparam logic [3:0] F1_BIT = 4'hB;

  // Register numbers with special timing
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CG = 4'h3;

  // Word that a subroutine return is encoded as (move @SP+ to PC)
  localparam logic [15:0] RET_WORD = 16'h4130;

  // ==================================================
  // Fixed cycle counts
  localparam logic [2:0] CYC_RETURN_FROM_INTERRUPT = 3'h5;
  localparam logic [2:0] CYC_RET = 3'h4;
  localparam logic [2:0] CYC_IRQ = 3'h6;
  localparam logic [2:0] CYC_RST = 3'h4;
  localparam logic [2:0] CYC_JUMP = 3'h2;

  // Operand class for timing lookup
  typedef enum logic [2:0] {
    ICT_AM_REG = 3'h0,
    ICT_AM_IND = 3'h1,
    ICT_AM_IMM = 3'h2,
    ICT_AM_IDX = 3'h3,
    ICT_AM_ABS = 3'h4
  } ict_am_t;

  // Sequencer states, Gray along reset -> fetch -> exec
  typedef enum logic [1:0] {
    ICT_ST_RESET = 2'b00,
    ICT_ST_FETCH = 2'b01,
    ICT_ST_EXEC = 2'b11,
    ICT_ST_IRQ = 2'b10
  } ict_state_t;

endpackage : ict_pkg

//--- verilog/ict_seq.sv
// Instruction cycle timing and length sequencer
module ict_seq (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wdt_reset,
  input wire logic pin_reset,
  input wire logic irq_req,
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  output logic fetch_req,
  output logic ins_start,
  output logic [2:0] ins_cycles,
  output logic [1:0] ins_words,
  output logic ext_active,
  output logic ext_reg_layout,
  output logic wide_operands,
  output logic illegal_mode,
  output logic irq_entry,
  output logic busy
);

  // ==================================================
  // Decode helpers
  function automatic ict_pkg::ict_am_t src_class(input logic [1:0] as,
                                                 input logic [3:0] rs);
    ict_pkg::ict_am_t c;
    c = ict_pkg::ICT_AM_REG;
    if (rs == ict_pkg::REG_CG) begin
      c = ict_pkg::ICT_AM_REG; // Constant generator acts as register
    end else if (rs == ict_pkg::REG_SR && as != 2'h0) begin
      c = (as == 2'h1) ? ict_pkg::ICT_AM_ABS : ict_pkg::ICT_AM_REG;
    end else begin
      unique case (as)
        2'h0: c = ict_pkg::ICT_AM_REG;
        2'h1: c = ict_pkg::ICT_AM_IDX;
        2'h2: c = ict_pkg::ICT_AM_IND;
        2'h3: c = (rs == ict_pkg::REG_PC) ? ict_pkg::ICT_AM_IMM :
                                            ict_pkg::ICT_AM_IND;
      endcase
    end
    return c;
  endfunction : src_class

  function automatic logic is_ext(input logic [15:0] w);
    return w[15:11] == ict_pkg::EXT_PREFIX;
  endfunction : is_ext

  // ==================================================
  // Single-operand cycle count by operand class
  function automatic logic [2:0] fmt2_cycles(input logic [2:0] op,
                                             input ict_pkg::ict_am_t c);
    logic [2:0] n;
    n = 3'h1;
    unique case (c)
      ict_pkg::ICT_AM_REG: begin
        if (op == ict_pkg::F2_PUSH) begin
          n = 3'h3;
        end else if (op == ict_pkg::F2_CALL) begin
          n = 3'h4;
        end else begin
          n = 3'h1;
        end
      end
      ict_pkg::ICT_AM_IND: begin
        if (op == ict_pkg::F2_CALL) begin
          n = 3'h4;
        end else begin
          n = 3'h3;
        end
      end
      ict_pkg::ICT_AM_IMM: begin
        if (op == ict_pkg::F2_CALL) begin
          n = 3'h4;
        end else begin
          n = 3'h3;
        end
      end
      ict_pkg::ICT_AM_IDX: begin
        if (op == ict_pkg::F2_CALL) begin
          n = 3'h5;
        end else begin
          n = 3'h4;
        end
      end
      ict_pkg::ICT_AM_ABS: begin
        if (op == ict_pkg::F2_CALL) begin
          n = 3'h6;
        end else begin
          n = 3'h4;
        end
      end
    endcase
    return n;
  endfunction : fmt2_cycles

  // Single-operand length: an operand word follows in immediate, indexed and absolute modes
  function automatic logic [1:0] fmt2_words(input ict_pkg::ict_am_t c);
    logic [1:0] n;
    n = 2'h2;
    if (c == ict_pkg::ICT_AM_REG || c == ict_pkg::ICT_AM_IND) begin
      n = 2'h1;
    end
    return n;
  endfunction : fmt2_words

  // Double-operand cycle count by source class and destination kind
  function automatic logic [2:0] fmt1_cycles(input ict_pkg::ict_am_t c,
                                             input logic mem,
                                             input logic pc);
    logic [2:0] n;
    n = 3'h1;
    unique case (c)
      ict_pkg::ICT_AM_REG: begin
        n = mem ? 3'h4 : (pc ? 3'h3 : 3'h1);
      end
      ict_pkg::ICT_AM_IND: begin
        n = mem ? 3'h5 : (pc ? 3'h4 : 3'h2);
      end
      ict_pkg::ICT_AM_IMM: begin
        n = mem ? 3'h5 : (pc ? 3'h3 : 3'h2);
      end
      ict_pkg::ICT_AM_IDX, ict_pkg::ICT_AM_ABS: begin
        n = mem ? 3'h6 : (pc ? 3'h5 : 3'h3);
      end
    endcase
    return n;
  endfunction : fmt1_cycles

  // Double-operand length: op word, plus source and destination words
  function automatic logic [1:0] fmt1_words(input ict_pkg::ict_am_t c,
                                            input logic mem);
    logic [1:0] n;
    n = 2'h1;
    if (c == ict_pkg::ICT_AM_IMM || c == ict_pkg::ICT_AM_IDX ||
        c == ict_pkg::ICT_AM_ABS) begin
      n = n + 2'h1;
    end
    if (mem) begin
      n = n + 2'h1;
    end
    return n;
  endfunction : fmt1_words

  // Operations that finish one cycle early on a memory destination
  function automatic logic early_finish(input logic [3:0] op);
    return op == ict_pkg::F1_MOV || op == ict_pkg::F1_CMP ||
           op == ict_pkg::F1_BIT;
  endfunction : early_finish

  // ==================================================
  // Combinational lookup of cycles and words
  ict_pkg::ict_am_t sc;
  logic [2:0] cyc_nxt;
  logic [1:0] words_nxt;
  logic bad_nxt;
  logic reg_modes;
  logic [2:0] f2op;
  logic [3:0] f1op;
  logic dst_mem;
  logic dst_pc;

  // Format first, then addressing modes, then the operation where it changes the count
  always_comb begin
    f2op = op_word[9:7];
    f1op = op_word[15:12];
    dst_mem = op_word[7];
    dst_pc = op_word[3:0] == ict_pkg::REG_PC;
    sc = ict_pkg::ICT_AM_REG;
    cyc_nxt = 3'h1;
    words_nxt = 2'h1;
    bad_nxt = 1'b0;
    reg_modes = op_word[5:4] == 2'h0;
    if (op_word == ict_pkg::RET_WORD) begin
      cyc_nxt = ict_pkg::CYC_RET;
      words_nxt = 2'h1;
    end else if (op_word[15:10] == ict_pkg::FMT2_TOP) begin
      sc = src_class(op_word[5:4], op_word[3:0]);
      if (f2op == ict_pkg::F2_RETURN_FROM_INTERRUPT) begin
        cyc_nxt = ict_pkg::CYC_RETURN_FROM_INTERRUPT;
        words_nxt = 2'h1;
      end else begin
        cyc_nxt = fmt2_cycles(f2op, sc);
        words_nxt = fmt2_words(sc);
        bad_nxt = sc == ict_pkg::ICT_AM_IMM &&
                  f2op != ict_pkg::F2_CALL &&
                  f2op != ict_pkg::F2_PUSH;
      end
    end else if (op_word[15:13] == ict_pkg::JUMP_TOP) begin
      cyc_nxt = ict_pkg::CYC_JUMP;
      words_nxt = 2'h1;
      reg_modes = 1'b0;
    end else begin
      sc = src_class(op_word[5:4], op_word[11:8]);
      cyc_nxt = fmt1_cycles(sc, dst_mem, dst_pc);
      words_nxt = fmt1_words(sc, dst_mem);
      reg_modes = reg_modes && !dst_mem;
      if (dst_mem && early_finish(f1op)) begin
        cyc_nxt = cyc_nxt - 3'h1;
      end
    end
  end

  // ==================================================
  // Sequencer state and cycle counter
  ict_pkg::ict_state_t state_r;
  logic [2:0] cnt_r;
  logic ext_pend_r;
  logic decode;
  logic last;

  // A word is taken only when an interrupt does not win the fetch slot
  assign last = cnt_r == 3'h1;
  assign decode = state_r == ict_pkg::ICT_ST_FETCH && op_valid &&
                  !(irq_req && !ext_pend_r);

  // State transitions; all three reset sources restart the sequence
  always_ff @(posedge clk) begin
    if (!reset_n || wdt_reset || pin_reset) begin
      state_r <= ict_pkg::ICT_ST_RESET;
      cnt_r <= ict_pkg::CYC_RST;
    end else begin
      unique case (state_r)
        ict_pkg::ICT_ST_RESET, ict_pkg::ICT_ST_IRQ: begin
          if (last) begin
            state_r <= ict_pkg::ICT_ST_FETCH;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ict_pkg::ICT_ST_FETCH: begin
          if (irq_req && !ext_pend_r) begin
            state_r <= ict_pkg::ICT_ST_IRQ;
            cnt_r <= ict_pkg::CYC_IRQ;
          end else if (op_valid && !is_ext(op_word)) begin
            state_r <= ict_pkg::ICT_ST_EXEC;
            cnt_r <= cyc_nxt;
          end
        end
        ict_pkg::ICT_ST_EXEC: begin
          if (last) begin
            state_r <= ict_pkg::ICT_ST_FETCH;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
      endcase
    end
  end

  // Extension prefix latch, cleared when its instruction starts
  always_ff @(posedge clk) begin
    if (!reset_n || wdt_reset || pin_reset) begin
      ext_pend_r <= 1'b0;
    end else if (decode && is_ext(op_word)) begin
      ext_pend_r <= 1'b1;
    end else if (decode) begin
      ext_pend_r <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fetch_req <= 1'b0;
      ins_start <= 1'b0;
      ins_cycles <= 3'h0;
      ins_words <= 2'h0;
      ext_active <= 1'b0;
      ext_reg_layout <= 1'b0;
      wide_operands <= 1'b0;
      illegal_mode <= 1'b0;
      irq_entry <= 1'b0;
      busy <= 1'b1;
    end else begin
      fetch_req <= state_r == ict_pkg::ICT_ST_FETCH ||
                   (state_r != ict_pkg::ICT_ST_FETCH && last);
      ins_start <= decode && !is_ext(op_word);
      if (decode && !is_ext(op_word)) begin
        ins_cycles <= cyc_nxt;
        ins_words <= words_nxt;
        illegal_mode <= bad_nxt;
        wide_operands <= ext_pend_r;
        ext_active <= ext_pend_r;
        ext_reg_layout <= ext_pend_r && reg_modes;
      end
      irq_entry <= state_r == ict_pkg::ICT_ST_IRQ;
      busy <= state_r != ict_pkg::ICT_ST_FETCH;
    end
  end

endmodule : ict_seq

//--- dv/ict_seq_asserts.sv
// Port checker of the instruction cycle timing sequencer
module ict_seq_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wdt_reset,
  input wire logic pin_reset,
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic ins_start,
  input wire logic [2:0] ins_cycles,
  input wire logic [1:0] ins_words,
  input wire logic ext_active,
  input wire logic wide_operands,
  input wire logic illegal_mode,
  input wire logic irq_entry,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] word_r;
  logic [15:0] prev_r;
  // ==================================================
  // Word last taken in fetch state, and the one before it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_r <= 16'h0000;
      prev_r <= 16'h0000;
    end else if (!busy && op_valid) begin
      word_r <= op_word;
      prev_r <= word_r;
    end
  end
  property p_ret_int;
    ins_start && word_r == 16'h1300 |-> ins_cycles == 3'h5 && ins_words == 2'h1;
  endproperty
  a_ret_int: assert property (p_ret_int) else $error("int return size");
  property p_ret_sub;
    ins_start && word_r == 16'h4130 |-> ins_cycles == 3'h4 && ins_words == 2'h1;
  endproperty
  a_ret_sub: assert property (p_ret_sub) else $error("sub return size");
  property p_irq_len;
    $rose(irq_entry) |-> irq_entry [*6] ##1 !irq_entry;
  endproperty
  a_irq_len: assert property (p_irq_len) else $error("irq entry length");
  property p_wdt_len;
    $fell(wdt_reset) |=> busy [*4] ##1 !busy;
  endproperty
  a_wdt_len: assert property (p_wdt_len) else $error("wdt reset length");
  property p_pin_len;
    $fell(pin_reset) |=> busy [*4] ##1 !busy;
  endproperty
  a_pin_len: assert property (p_pin_len) else $error("pin reset length");
  property p_imm_shift;
    ins_start && word_r[15:10] == 6'h04 && word_r[9:7] < 3'h4
      && word_r[5:0] == 6'h30 |-> illegal_mode;
  endproperty
  a_imm_shift: assert property (p_imm_shift) else $error("no illegal flag");
  property p_jump;
    ins_start && word_r[15:13] == 3'h1 |-> ins_cycles == 3'h2 && ins_words == 2'h1;
  endproperty
  a_jump: assert property (p_jump) else $error("jump size");
  property p_reg_reg;
    ins_start && word_r[15:14] != 2'h0 && !word_r[7] && word_r[5:4] == 2'h0
      && word_r[3:0] != 4'h0 |-> ins_cycles == 3'h1 && ins_words == 2'h1;
  endproperty
  a_reg_reg: assert property (p_reg_reg) else $error("reg move size");
  property p_wide;
    ins_start |-> wide_operands == (prev_r[15:11] == 5'h03) &&
      ext_active == wide_operands;
  endproperty
  a_wide: assert property (p_wide) else $error("not wide");
  property p_prefix;
    !busy && op_valid && op_word[15:11] == 5'h03 |=> !ins_start;
  endproperty
  a_prefix: assert property (p_prefix) else $error("prefix counted");
  property p_busy4;
    ins_start && ins_cycles == 3'h4 |=> busy [*4] ##1 !busy;
  endproperty
  a_busy4: assert property (p_busy4) else $error("busy length");
  c_irq: cover property ($rose(irq_entry));
  c_ext: cover property (ins_start && ext_active);
  c_bad: cover property (ins_start && illegal_mode);
endmodule : ict_seq_asserts

bind ict_seq ict_seq_asserts i_ict_seq_asserts (.clk(clk), .reset_n(reset_n),
  .wdt_reset(wdt_reset), .pin_reset(pin_reset), .op_valid(op_valid),
  .op_word(op_word), .ins_start(ins_start), .ins_cycles(ins_cycles),
  .ins_words(ins_words), .ext_active(ext_active),
  .wide_operands(wide_operands), .illegal_mode(illegal_mode),
  .irq_entry(irq_entry), .busy(busy));

//--- dv/test_ict_seq.sv
// Self-checking bench of the instruction cycle timing sequencer
module test_ict_seq;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wdt_reset = 1'b0;
  logic pin_reset = 1'b0;
  logic irq_req = 1'b0;
  logic op_valid = 1'b0;
  logic [15:0] op_word = 16'h0000;
  logic fetch_req, ins_start, ext_active, ext_reg_layout, wide_operands;
  logic illegal_mode, irq_entry, busy;
  logic [2:0] ins_cycles;
  logic [1:0] ins_words;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int k;
  // ==================================================
  // Clock, design and hang guard
  always #12.5 clk = ~clk;
  ict_seq i_ict_seq (.clk(clk), .reset_n(reset_n), .wdt_reset(wdt_reset),
    .pin_reset(pin_reset), .irq_req(irq_req), .op_valid(op_valid),
    .op_word(op_word), .fetch_req(fetch_req), .ins_start(ins_start),
    .ins_cycles(ins_cycles), .ins_words(ins_words), .ext_active(ext_active),
    .ext_reg_layout(ext_reg_layout), .wide_operands(wide_operands),
    .illegal_mode(illegal_mode), .irq_entry(irq_entry), .busy(busy));
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==================================================
  // Shared tasks
  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge clk);
    #2;
  endtask : step
  task automatic wait_busy(output int n);
    step();
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      step();
      n++;
    end
  endtask : wait_busy
  task automatic put(input logic [15:0] w);
    op_valid = 1'b1;
    op_word = w;
    step();
    op_valid = 1'b0;
  endtask : put
  task automatic run(input logic [15:0] w, input logic [2:0] c,
                     input logic [1:0] n);
    int b;
    put(w);
    chk(8'(ins_start), 8'h01);
    chk(8'(ins_cycles), 8'(c));
    chk(8'(ins_words), 8'(n));
    wait_busy(b);
    chk(8'(b), 8'(c));
    chk(8'(fetch_req), 8'h01);
  endtask : run
  // ==================================================
  // Scenarios
  task automatic t_fixed();
    run(16'h1300, 3'h5, 2'h1);
    run(16'h4130, 3'h4, 2'h1);
    run(16'h2000, 3'h2, 2'h1);
    run(16'h3C00, 3'h2, 2'h1);
    $display("t_fixed done");
  endtask : t_fixed
  task automatic t_fmt2();
    int i;
    for (i = 0; i < 4; i++) begin
      run(16'h1005 | 16'(i << 7), 3'h1, 2'h1);
      run(16'h1029 | 16'(i << 7), 3'h3, 2'h1);
      run(16'h1015 | 16'(i << 7), 3'h4, 2'h2);
      put(16'h1030 | 16'(i << 7));
      chk(8'(illegal_mode), 8'h01);
      wait_busy(k);
    end
    run(16'h1205, 3'h3, 2'h1);
    run(16'h1285, 3'h4, 2'h1);
    run(16'h12B5, 3'h4, 2'h1);
    run(16'h1230, 3'h3, 2'h2);
    chk(8'(illegal_mode), 8'h00);
    run(16'h12B0, 3'h4, 2'h2);
    run(16'h1297, 3'h5, 2'h2);
    run(16'h1290, 3'h5, 2'h2);
    run(16'h1292, 3'h6, 2'h2);
    $display("t_fmt2 done");
  endtask : t_fmt2
  task automatic t_fmt1();
    run(16'h5508, 3'h1, 2'h1);
    run(16'h5900, 3'h3, 2'h1);
    run(16'h5586, 3'h4, 2'h2);
    run(16'h4582, 3'h3, 2'h2);
    run(16'h5425, 3'h2, 2'h1);
    run(16'h5820, 3'h4, 2'h1);
    run(16'h55B6, 3'h5, 2'h2);
    run(16'h95A0, 3'h4, 2'h2);
    run(16'h5039, 3'h2, 2'h2);
    run(16'h5030, 3'h3, 2'h2);
    run(16'h50B0, 3'h5, 2'h3);
    run(16'hB0B2, 3'h4, 2'h3);
    run(16'h5517, 3'h3, 2'h2);
    run(16'h5510, 3'h5, 2'h2);
    run(16'h5499, 3'h6, 2'h3);
    run(16'h4492, 3'h5, 2'h3);
    $display("t_fmt1 done");
  endtask : t_fmt1
  task automatic t_ext();
    put(16'h1800);
    wait_busy(k);
    run(16'h5508, 3'h1, 2'h1);
    chk(8'(ext_active), 8'h01);
    chk(8'(ext_reg_layout), 8'h01);
    chk(8'(wide_operands), 8'h01);
    put(16'h1FFF);
    wait_busy(k);
    run(16'h50B0, 3'h5, 2'h3);
    chk(8'(ext_active), 8'h01);
    chk(8'(ext_reg_layout), 8'h00);
    run(16'h5508, 3'h1, 2'h1);
    chk(8'(ext_active), 8'h00);
    chk(8'(wide_operands), 8'h00);
    $display("t_ext done");
  endtask : t_ext
  task automatic t_irq();
    int n;
    irq_req = 1'b1;
    step();
    irq_req = 1'b0;
    step();
    n = 0;
    while (irq_entry === 1'b1 && n < 20) begin
      step();
      n++;
    end
    chk(8'(n), 8'h06);
    wait_busy(k);
    run(16'h2000, 3'h2, 2'h1);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_rst();
    int i;
    for (i = 0; i < 2; i++) begin
      wdt_reset = (i == 0);
      pin_reset = (i == 1);
      step();
      wdt_reset = 1'b0;
      pin_reset = 1'b0;
      wait_busy(k);
      chk(8'(k), 8'h04);
      run(16'h5508, 3'h1, 2'h1);
    end
    $display("t_rst done");
  endtask : t_rst
  // ==================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2;
    reset_n = 1'b1;
    wait_busy(k);
    t_fixed();
    t_fmt2();
    t_fmt1();
    t_ext();
    t_irq();
    t_rst();
    end_of_test();
  end
endmodule : test_ict_seq
